// ---- logic/chan_switch_top.sv ----
// four-channel bus switch: serial slave, channel-select register, line repeaters
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"

module chan_switch_top
    import chan_switch_pkg::*;
#(
    parameter logic [3:0] DEVICE_CODE = `CSW_DEVICE_CODE,
    parameter int N = `CSW_CHANNELS
) (
    // core clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // link sampling clock
    input wire logic i_link_clk,
    // address straps
    input wire logic i_addr_strap_bit0,
    input wire logic i_addr_strap_bit1,
    input wire logic i_addr_strap_bit2,
    // upstream clock line
    input wire logic i_up_scl,
    output logic o_up_scl_o,
    output logic o_up_scl_oe_n,
    // upstream data line
    input wire logic i_up_sda,
    output logic o_up_sda_o,
    output logic o_up_sda_oe_n,
    // downstream clock lines
    input wire logic [N-1:0] i_downstream_clock_n,
    output logic [N-1:0] o_downstream_clock_n_o,
    output logic [N-1:0] o_downstream_clock_n_oe_n,
    // downstream data lines
    input wire logic [N-1:0] i_downstream_data_n,
    output logic [N-1:0] o_downstream_data_n_o,
    output logic [N-1:0] o_downstream_data_n_oe_n,
    // channel status
    output logic [N-1:0] o_chan_enable
);
    // ---------------- link domain ----------------
    logic link_rst_n;
    logic [1:0] bus_s;
    logic [2:0] strap_s;
    logic scl_s;
    logic sda_s;
    logic scl_prev_q;
    logic sda_prev_q;
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    logic byte_done;
    logic addr_match;
    logic wr_byte;

    link_state_t state_q;
    logic [`CSW_BITCNT_W-1:0] bit_cnt_q;
    logic [`CSW_BYTE_BITS-1:0] rx_q;
    logic [`CSW_BYTE_BITS-1:0] tx_q;
    logic sda_low_q;
    logic nack_q;
    logic [`CSW_BYTE_BITS-1:0] select_q;
    logic written_q;
    logic [N-1:0] active_q;
    logic commit_tgl_q;

    // reset reaches the link side through its own synchroniser
    sync_2ff #(.W(1)) u_link_rst_sync (
        .i_clk(i_link_clk),
        .i_d(i_reset_n),
        .o_q(link_rst_n)
    );

    sync_2ff #(.W(2)) u_bus_sync (
        .i_clk(i_link_clk),
        .i_d({i_up_scl, i_up_sda}),
        .o_q(bus_s)
    );

    sync_2ff #(.W(3)) u_strap_sync (
        .i_clk(i_link_clk),
        .i_d({i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0}),
        .o_q(strap_s)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // oversampled, so any bus rate up to the fast mode limit is seen
    always_comb begin
        start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
        stop_ev = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
        scl_rise = scl_s & ~scl_prev_q;
        scl_fall = ~scl_s & scl_prev_q;
        byte_done = scl_fall & (bit_cnt_q == `CSW_BITCNT_FULL);
        addr_match = (rx_q[`CSW_ADDR_HI:`CSW_ADDR_LO] == {DEVICE_CODE, strap_s});
        wr_byte = (state_q == LK_WR_DATA) & byte_done;
    end

    // serial slave state machine
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            state_q <= LK_IDLE;
            bit_cnt_q <= `CSW_BITCNT_ZERO;
            rx_q <= `CSW_SELECT_RESET;
            tx_q <= `CSW_SELECT_RESET;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (start_ev) begin
            state_q <= LK_ADDR;
            bit_cnt_q <= `CSW_BITCNT_ZERO;
            sda_low_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= LK_IDLE;
            sda_low_q <= 1'b0;
        end else begin
            if (scl_rise && bit_cnt_q != `CSW_BITCNT_FULL) begin
                rx_q <= {rx_q[`CSW_BYTE_BITS-2:0], sda_s};
                bit_cnt_q <= bit_cnt_q + `CSW_BITCNT_ONE;
            end
            unique case (state_q)
                LK_IDLE: begin
                    sda_low_q <= 1'b0;
                end
                LK_ADDR: begin
                    if (byte_done) begin
                        if (addr_match) begin
                            sda_low_q <= 1'b1;
                            state_q <= LK_ADDR_ACK;
                        end else begin
                            state_q <= LK_IDLE;
                        end
                    end
                end
                LK_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= `CSW_BITCNT_ZERO;
                        if (rx_q[`CSW_ADDR_RW_BIT] == `CSW_RW_READ) begin
                            sda_low_q <= ~select_q[`CSW_BYTE_BITS-1];
                            tx_q <= {select_q[`CSW_BYTE_BITS-2:0], 1'b0};
                            state_q <= LK_RD_DATA;
                        end else begin
                            sda_low_q <= 1'b0;
                            state_q <= LK_WR_DATA;
                        end
                    end
                end
                LK_WR_DATA: begin
                    if (byte_done) begin
                        sda_low_q <= 1'b1;
                        state_q <= LK_WR_ACK;
                    end
                end
                LK_WR_ACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        bit_cnt_q <= `CSW_BITCNT_ZERO;
                        state_q <= LK_WR_DATA;
                    end
                end
                LK_RD_DATA: begin
                    if (byte_done) begin
                        sda_low_q <= 1'b0;
                        state_q <= LK_RD_ACK;
                    end else if (scl_fall) begin
                        sda_low_q <= ~tx_q[`CSW_BYTE_BITS-1];
                        tx_q <= {tx_q[`CSW_BYTE_BITS-2:0], 1'b0};
                    end
                end
                LK_RD_ACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end
                    if (scl_fall) begin
                        bit_cnt_q <= `CSW_BITCNT_ZERO;
                        if (nack_q) begin
                            // master ends the read; wait for its stop
                            state_q <= LK_IDLE;
                        end else begin
                            sda_low_q <= ~select_q[`CSW_BYTE_BITS-1];
                            tx_q <= {select_q[`CSW_BYTE_BITS-2:0], 1'b0};
                            state_q <= LK_RD_DATA;
                        end
                    end
                end
                // the eighth code of the state type is never entered
                default: begin
                    state_q <= LK_IDLE;
                end
            endcase
        end
    end

    // select register: every written byte overwrites, the last one stays
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            select_q <= `CSW_SELECT_RESET;
        end else if (wr_byte) begin
            select_q <= rx_q;
        end
    end

    // new selection is held back until the stop, when all lines are high
    always_ff @(posedge i_link_clk) begin
        if (!link_rst_n) begin
            written_q <= 1'b0;
            active_q <= `CSW_ENABLE_RESET;
            commit_tgl_q <= 1'b0;
        end else if (stop_ev && written_q) begin
            written_q <= 1'b0;
            active_q <= select_q[`CSW_CHAN_HI:0];
            commit_tgl_q <= ~commit_tgl_q;
        end else if (wr_byte) begin
            written_q <= 1'b1;
        end else if (start_ev) begin
            // a repeated start without a stop drops the pending write
            written_q <= 1'b0;
        end
    end

    // ---------------- core domain ----------------
    logic core_rst_n;
    logic tgl_s;
    logic tgl_prev_q;
    logic slave_low_s;
    logic [N-1:0] enable_q;
    logic [1:0] up_s;
    logic [N-1:0] ds_clk_s;
    logic [N-1:0] ds_dat_s;
    logic rep_scl_up;
    logic rep_sda_up;

    // the reset pin reaches the core logic through two flops as well
    sync_2ff #(.W(1)) u_core_rst_sync (
        .i_clk(i_clk),
        .i_d(i_reset_n),
        .o_q(core_rst_n)
    );

    sync_2ff #(.W(2)) u_evt_sync (
        .i_clk(i_clk),
        .i_d({commit_tgl_q, sda_low_q}),
        .o_q({tgl_s, slave_low_s})
    );

    sync_2ff #(.W(2 + 2 * N)) u_line_sync (
        .i_clk(i_clk),
        .i_d({i_up_scl, i_up_sda, i_downstream_clock_n, i_downstream_data_n}),
        .o_q({up_s, ds_clk_s, ds_dat_s})
    );

    // active_q changes with each toggle and is then stable for many link cycles
    always_ff @(posedge i_clk) begin
        if (!core_rst_n) begin
            tgl_prev_q <= 1'b0;
            enable_q <= `CSW_ENABLE_RESET;
        end else begin
            tgl_prev_q <= tgl_s;
            if (tgl_s != tgl_prev_q) begin
                enable_q <= active_q;
            end
        end
    end

    line_repeater #(.N(N)) u_scl_rep (
        .i_clk(i_clk),
        .i_reset_n(core_rst_n),
        .i_up_low(~up_s[1]),
        .i_down_low(~ds_clk_s),
        .i_enable(enable_q),
        .o_drive_up_q(rep_scl_up),
        .o_down_oe_n_q(o_downstream_clock_n_oe_n)
    );

    line_repeater #(.N(N)) u_sda_rep (
        .i_clk(i_clk),
        .i_reset_n(core_rst_n),
        .i_up_low(~up_s[0]),
        .i_down_low(~ds_dat_s),
        .i_enable(enable_q),
        .o_drive_up_q(rep_sda_up),
        .o_down_oe_n_q(o_downstream_data_n_oe_n)
    );

    // open-drain: the driven level is always low, only the enables move
    always_ff @(posedge i_clk) begin
        if (!core_rst_n) begin
            o_up_scl_oe_n <= 1'b1;
            o_up_sda_oe_n <= 1'b1;
        end else begin
            o_up_scl_oe_n <= ~rep_scl_up;
            o_up_sda_oe_n <= ~(rep_sda_up | slave_low_s);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!core_rst_n) begin
            o_up_scl_o <= 1'b0;
            o_up_sda_o <= 1'b0;
            o_downstream_clock_n_o <= '0;
            o_downstream_data_n_o <= '0;
        end else begin
            o_up_scl_o <= 1'b0;
            o_up_sda_o <= 1'b0;
            o_downstream_clock_n_o <= '0;
            o_downstream_data_n_o <= '0;
        end
    end

    assign o_chan_enable = enable_q;
endmodule

// ---- logic/chan_switch_cfg.svh ----
// shared constants of the four-channel bus switch controller
`ifndef CHAN_SWITCH_CFG_SVH
`define CHAN_SWITCH_CFG_SVH

`define CSW_CHANNELS 4
`define CSW_BYTE_BITS 8
`define CSW_SELECT_RESET 8'h00
`define CSW_ENABLE_RESET 4'h0
`define CSW_BITCNT_W 4
`define CSW_BITCNT_ZERO 4'h0
`define CSW_BITCNT_ONE 4'h1
`define CSW_BITCNT_FULL 4'h8
`define CSW_ADDR_RW_BIT 0
`define CSW_ADDR_HI 7
`define CSW_ADDR_LO 1
`define CSW_CHAN_HI 3
`define CSW_RW_READ 1'b1
`define CSW_DEVICE_CODE 4'hE
`define CSW_HOLD_W 3
`define CSW_HOLD_CYC 3'h6
`define CSW_HOLD_ZERO 3'h0
`define CSW_HOLD_STEP 3'h1

`endif

// ---- logic/chan_switch_pkg.sv ----
// state types of the four-channel bus switch controller
package chan_switch_pkg;

    typedef enum logic [2:0] {
        LK_IDLE,
        LK_ADDR,
        LK_ADDR_ACK,
        LK_WR_DATA,
        LK_WR_ACK,
        LK_RD_DATA,
        LK_RD_ACK
    } link_state_t;

    typedef enum logic [1:0] {
        RP_IDLE,
        RP_UP_OWNS,
        RP_DOWN_OWNS,
        RP_HOLD
    } rep_state_t;

endpackage

// ---- logic/sync_2ff.sv ----
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module sync_2ff #(
    parameter int W = 1
) (
    // clock
    input wire logic i_clk,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    // no reset: also used to bring the reset itself into a domain
    logic [W-1:0] meta_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_d;
        stable_q <= meta_q;
    end

    assign o_q = stable_q;
endmodule

// ---- logic/line_repeater.sv ----
// one bus line passed between the upstream side and the enabled channels
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"
module line_repeater
    import chan_switch_pkg::*;
#(
    parameter int N = `CSW_CHANNELS
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // sampled line levels
    input wire logic i_up_low,
    input wire logic [N-1:0] i_down_low,
    input wire logic [N-1:0] i_enable,
    // drives
    output logic o_drive_up_q,
    output logic [N-1:0] o_down_oe_n_q
);
    rep_state_t state_q;
    logic [`CSW_HOLD_W-1:0] hold_q;
    logic down_any_low;

    assign down_any_low = |(i_enable & i_down_low);

    // the side that pulls low first owns the line until it lets go
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q <= RP_IDLE;
            hold_q <= `CSW_HOLD_ZERO;
            o_drive_up_q <= 1'b0;
            o_down_oe_n_q <= '1;
        end else begin
            unique case (state_q)
                RP_IDLE: begin
                    if (i_up_low) begin
                        state_q <= RP_UP_OWNS;
                        o_down_oe_n_q <= ~i_enable;
                    end else if (down_any_low) begin
                        state_q <= RP_DOWN_OWNS;
                        o_drive_up_q <= 1'b1;
                    end
                end
                RP_UP_OWNS: begin
                    o_down_oe_n_q <= ~i_enable;
                    if (!i_up_low) begin
                        o_down_oe_n_q <= '1;
                        hold_q <= `CSW_HOLD_CYC;
                        state_q <= RP_HOLD;
                    end
                end
                RP_DOWN_OWNS: begin
                    if (!down_any_low) begin
                        o_drive_up_q <= 1'b0;
                        hold_q <= `CSW_HOLD_CYC;
                        state_q <= RP_HOLD;
                    end
                end
                RP_HOLD: begin
                    // our own release is still in the sampling path; ignore it
                    if (hold_q == `CSW_HOLD_ZERO) begin
                        state_q <= RP_IDLE;
                    end else begin
                        hold_q <= hold_q - `CSW_HOLD_STEP;
                    end
                end
            endcase
        end
    end
endmodule

// ---- dv/chan_switch_sva.sv ----
// pin-level assertions of the bus switch controller
`timescale 1ns/1ps
module chan_switch_sva #(
    parameter logic [3:0] DEVICE_CODE = 4'hE,
    parameter int N = 4
) (
    // clocks and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_link_clk,
    // straps
    input wire logic i_addr_strap_bit0,
    input wire logic i_addr_strap_bit1,
    input wire logic i_addr_strap_bit2,
    // upstream
    input wire logic i_up_scl,
    input wire logic o_up_scl_o,
    input wire logic o_up_scl_oe_n,
    input wire logic i_up_sda,
    input wire logic o_up_sda_o,
    input wire logic o_up_sda_oe_n,
    // downstream
    input wire logic [N-1:0] i_downstream_clock_n,
    input wire logic [N-1:0] o_downstream_clock_n_o,
    input wire logic [N-1:0] o_downstream_clock_n_oe_n,
    input wire logic [N-1:0] i_downstream_data_n,
    input wire logic [N-1:0] o_downstream_data_n_o,
    input wire logic [N-1:0] o_downstream_data_n_oe_n,
    input wire logic [N-1:0] o_chan_enable
);
    wire [N-1:0] dn_oe_n = o_downstream_clock_n_oe_n & o_downstream_data_n_oe_n;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    property p_reset_idle;
        $rose(i_reset_n) |-> o_chan_enable == '0 && &dn_oe_n && o_up_scl_oe_n && o_up_sda_oe_n;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle");
    property p_reset_hold;
        $rose(i_reset_n) |-> (o_chan_enable == '0) [*8];
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("on at reset");
    property p_open_drain;
        !(o_up_scl_o || o_up_sda_o || (|o_downstream_clock_n_o) || (|o_downstream_data_n_o));
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("driven high");
    property p_off_channel;
        (~($past(o_chan_enable) | o_chan_enable) & ~dn_oe_n) == '0;
    endproperty
    a_off_channel: assert property (p_off_channel) else $error("off driven");
    property p_sel_at_stop;
        $changed(o_chan_enable) |-> i_up_scl && i_up_sda;
    endproperty
    a_sel_at_stop: assert property (p_sel_at_stop) else $error("not at idle");
    // only falls the master made itself, not our own drive coming back
    property p_down_follow;
        $fell(i_up_scl) && o_up_scl_oe_n
            |-> ##[1:12] (o_downstream_clock_n_oe_n & o_chan_enable) == '0;
    endproperty
    a_down_follow: assert property (p_down_follow) else $error("no clock down");
    property p_data_down;
        $fell(i_up_sda) && o_up_sda_oe_n
            |-> ##[1:12] (o_downstream_data_n_oe_n & o_chan_enable) == '0;
    endproperty
    a_data_down: assert property (p_data_down) else $error("no data down");
    property p_up_follow;
        $rose(|(~i_downstream_clock_n & o_downstream_clock_n_oe_n & o_chan_enable)) && i_up_scl
            |-> ##[1:12] !o_up_scl_oe_n;
    endproperty
    a_up_follow: assert property (p_up_follow) else $error("no clock up");
    property p_sda_steady;
        $changed(o_up_sda_oe_n) |-> !i_up_scl;
    endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("sda in high");

    c_select: cover property (o_chan_enable == 4'h5);
    c_ack: cover property ($fell(o_up_sda_oe_n));
    c_up_drive: cover property ($fell(o_up_scl_oe_n));
endmodule

bind chan_switch_top chan_switch_sva #(.DEVICE_CODE(DEVICE_CODE), .N(N)) u_sva (
    .i_clk, .i_reset_n, .i_link_clk,
    .i_addr_strap_bit0, .i_addr_strap_bit1, .i_addr_strap_bit2,
    .i_up_scl, .o_up_scl_o, .o_up_scl_oe_n, .i_up_sda, .o_up_sda_o, .o_up_sda_oe_n,
    .i_downstream_clock_n, .o_downstream_clock_n_o, .o_downstream_clock_n_oe_n,
    .i_downstream_data_n, .o_downstream_data_n_o, .o_downstream_data_n_oe_n,
    .o_chan_enable
);

// ---- dv/i2c_master_model.sv ----
// upstream bus master model: start, stop and byte transfers
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int TQ = 63
) (
    // pacing clock
    input wire logic i_clk,
    // resolved lines
    input wire logic i_scl,
    input wire logic i_sda,
    // open-drain drives, low pulls the wire
    output logic o_scl_oe_n,
    output logic o_sda_oe_n
);
    initial begin
        o_scl_oe_n = 1'b1;
        o_sda_oe_n = 1'b1;
    end

    // quarter bit of 63 cycles keeps the clock just under 400 kHz
    task automatic wait_q();
        repeat (TQ) @(negedge i_clk);
    endtask

    task automatic start_c();
        o_sda_oe_n = 1'b1;
        wait_q();
        o_scl_oe_n = 1'b1;
        wait_q();
        o_sda_oe_n = 1'b0;
        wait_q();
        o_scl_oe_n = 1'b0;
        wait_q();
    endtask

    // data only moves while the clock is low
    task automatic bit_io(input logic b, output logic s);
        o_sda_oe_n = b;
        wait_q();
        o_scl_oe_n = 1'b1;
        wait_q();
        s = i_sda;
        wait_q();
        o_scl_oe_n = 1'b0;
        wait_q();
    endtask

    task automatic byte_io(input logic [7:0] b_out, input logic ack_out,
                           output logic [7:0] b_in, output logic ack_in);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b_out[i], s);
            b_in[i] = s;
        end
        bit_io(ack_out, ack_in);
    endtask

    task automatic stop_c();
        o_sda_oe_n = 1'b0;
        wait_q();
        o_scl_oe_n = 1'b1;
        wait_q();
        o_sda_oe_n = 1'b1;
        wait_q();
    endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench of the bus switch controller
`timescale 1ns/1ps
`include "chan_switch_cfg.svh"
module tb_top;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] strap = 3'h5;
    logic [3:0] ds_clk_oe_n = 4'hF;
    wire m_scl_oe_n;
    wire m_sda_oe_n;
    wire u_scl_oe_n;
    wire u_sda_oe_n;
    wire [3:0] u_dclk_oe_n;
    wire [3:0] u_ddat_oe_n;
    wire [3:0] en;
    wire up_scl = m_scl_oe_n & u_scl_oe_n;
    wire up_sda = m_sda_oe_n & u_sda_oe_n;
    wire [3:0] ds_clk = ds_clk_oe_n & u_dclk_oe_n;
    wire [3:0] ds_dat = u_ddat_oe_n;
    int n_mismatch = 0;
    int compares = 0;

    initial begin
        forever #5 clk = ~clk;
    end
    // phase offset keeps the link clock unrelated to the core clock
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    chan_switch_top uut (
        .i_clk(clk), .i_reset_n(reset_n), .i_link_clk(link_clk),
        .i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]), .i_addr_strap_bit2(strap[2]),
        .i_up_scl(up_scl), .o_up_scl_o(), .o_up_scl_oe_n(u_scl_oe_n),
        .i_up_sda(up_sda), .o_up_sda_o(), .o_up_sda_oe_n(u_sda_oe_n),
        .i_downstream_clock_n(ds_clk), .o_downstream_clock_n_o(),
        .o_downstream_clock_n_oe_n(u_dclk_oe_n),
        .i_downstream_data_n(ds_dat), .o_downstream_data_n_o(),
        .o_downstream_data_n_oe_n(u_ddat_oe_n), .o_chan_enable(en)
    );

    i2c_master_model m (
        .i_clk(clk), .i_scl(up_scl), .i_sda(up_sda),
        .o_scl_oe_n(m_scl_oe_n), .o_sda_oe_n(m_sda_oe_n)
    );

    task automatic conclude();
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    // address, two data bytes, stop; only the second byte should stay
    task automatic wreg(input logic [2:0] st, input logic [3:0] dc, input logic [7:0] d0,
                        input logic [7:0] d1, input logic nack, input logic [3:0] en_prev);
        logic [7:0] rd;
        logic a;
        m.start_c();
        m.byte_io({dc, st, 1'b0}, 1'b1, rd, a);
        check("address ack", {7'h00, nack}, {7'h00, a});
        m.byte_io(d0, 1'b1, rd, a);
        check("data ack", {7'h00, nack}, {7'h00, a});
        m.byte_io(d1, 1'b1, rd, a);
        check("last data ack", {7'h00, nack}, {7'h00, a});
        check("enable before stop", {4'h0, en_prev}, {4'h0, en});
        m.stop_c();
        repeat (30) @(negedge clk);
    endtask

    // master acknowledges the first byte, so the register comes out twice
    task automatic rreg(input logic [2:0] st, input logic [7:0] exp);
        logic [7:0] rd;
        logic a;
        m.start_c();
        m.byte_io({`CSW_DEVICE_CODE, st, 1'b1}, 1'b1, rd, a);
        check("read address ack", 8'h00, {7'h00, a});
        m.byte_io(8'hFF, 1'b0, rd, a);
        check("read data", exp, rd);
        m.byte_io(8'hFF, 1'b1, rd, a);
        check("read data again", exp, rd);
        check("line free after read", 8'h01, {7'h00, a});
        m.stop_c();
        repeat (30) @(negedge clk);
    endtask

    task automatic pull_down(input int ch, input logic [7:0] exp);
        ds_clk_oe_n[ch] = 1'b0;
        repeat (20) @(negedge clk);
        check("upstream clock", exp, {7'h00, up_scl});
        ds_clk_oe_n[ch] = 1'b1;
        repeat (20) @(negedge clk);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (20) @(negedge clk);
        check("enable after reset", 8'h00, {4'h0, en});
        wreg(3'h4, `CSW_DEVICE_CODE, 8'h0F, 8'h0F, 1'b1, 4'h0);
        wreg(3'h5, `CSW_DEVICE_CODE ^ 4'h1, 8'h0F, 8'h0F, 1'b1, 4'h0);
        check("enable after refusal", 8'h00, {4'h0, en});
        wreg(3'h5, `CSW_DEVICE_CODE, 8'hFA, 8'h05, 1'b0, 4'h0);
        check("enable after stop", 8'h05, {4'h0, en});
        rreg(3'h5, 8'h05);
        pull_down(2, 8'h00);
        pull_down(1, 8'h01);
        strap = 3'h2;
        repeat (20) @(negedge clk);
        wreg(3'h2, `CSW_DEVICE_CODE, 8'h03, 8'hF0, 1'b0, 4'h5);
        check("enable of upper bits", 8'h00, {4'h0, en});
        rreg(3'h2, 8'hF0);
        wreg(3'h2, `CSW_DEVICE_CODE, 8'h01, 8'h0E, 1'b0, 4'h0);
        check("enable three channels", 8'h0E, {4'h0, en});
        reset_n = 1'b0;
        repeat (16) @(negedge clk);
        check("enable in reset", 8'h00, {4'h0, en});
        reset_n = 1'b1;
        repeat (20) @(negedge clk);
        rreg(3'h2, 8'h00);
        conclude();
    end

    initial begin
        #900000;
        n_mismatch++;
        conclude();
    end
endmodule
